/* File: rtl/dcc_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// - Factory parameter group refuses read and write
// - Reject run-locked writes while running; never-modifiable
// - Top-bit address writes RAM only, no commit
// - Reads of top-bit alias addresses are invalid
// - Run command decodes eight command codes
// - Frequency limits accept zero to maximum frequency
// - Process setpoint and feedback accept 0..1000
// - Torque reference accepts -3000..+3000
// - Torque limits accept 0..3000
// - Special word bits 1..0 pick motor
// - Special bits: torque disable, energy clear, etc
// - Virtual inputs hold ten bits
// - Virtual outputs hold four bits
// - Voltage reference accepts 0..1000
// - Analog outputs accept -1000..+1000
// - State word one reports six codes
// - State word two: ready, active motor
module dcc_regs
   import dcc_pkg::*;
#(
   parameter logic [15:0] FMAX = 16'h9C40 // Max frequency, 0.01 Hz units
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Access from the protocol engine
   input wire dcc_req_s req,
   output dcc_rsp_s rsp,
   // Parameter store and its lock flags
   output dcc_par_s par,
   input wire logic [15:0] par_rdata,
   input wire logic par_run_locked,
   input wire logic par_read_only,
   // Drive status inputs
   input wire logic drv_running,
   input wire logic drv_reverse,
   input wire logic drv_fault,
   input wire logic drv_power_off,
   input wire logic drv_preexcited,
   input wire logic drv_ready,
   // Control outputs
   output dcc_ctl_s ctl,
   output logic [15:0] freq_ref,
   output logic [15:0] proc_set,
   output logic [15:0] proc_fb,
   output logic [15:0] torq_ref,
   output logic [15:0] fwd_lim,
   output logic [15:0] rev_lim,
   output logic [15:0] mot_tlim,
   output logic [15:0] brk_tlim,
   output logic [9:0] vin,
   output logic [3:0] vout,
   output logic [15:0] volt_ref,
   output logic [15:0] ao_one,
   output logic [15:0] ao_two
);

   ////////////////////////////////////////////////////////////////////////
   // Address classification
   logic in_ctl_bank; // Control or state bank
   logic alias_addr; // RAM-only alias
   logic factory_addr; // Factory group
   logic [15:0] wsg; // Write data as signed
   logic range_ok; // Write value in range
   logic cmd_ok; // Defined run code
   logic [15:0] run_cmd_r; // Last accepted run command
   logic [5:0] special_r; // Special control bits

   assign alias_addr = req.addr[DCC_ALIAS_BIT];
   assign in_ctl_bank = (req.addr[15:8] == DCC_A_RUN_CMD[15:8]) ||
                        (req.addr[15:8] == DCC_A_STATE1[15:8]);
   // Group byte ignores the alias bit so aliases stay locked too
   assign factory_addr = ({1'b0, req.addr[14:8]} == DCC_FACTORY_GROUP);
   assign wsg = req.wdata;
   assign cmd_ok = (req.wdata >= DCC_CMD_FWD) &&
                   (req.wdata <= DCC_CMD_JOG_STOP);

   ////////////////////////////////////////////////////////////////////////
   // Range check of a control-bank write; out of range is refused
   always_comb begin
      unique case (req.addr)
         DCC_A_RUN_CMD: range_ok = cmd_ok;
         DCC_A_FREQ_REF: range_ok = (req.wdata <= FMAX);
         DCC_A_FWD_LIM, DCC_A_REV_LIM: range_ok = (req.wdata <= FMAX);
         DCC_A_PROC_SET, DCC_A_PROC_FB: range_ok = (req.wdata <= DCC_PCT_MAX);
         DCC_A_TORQ_REF: range_ok = ($signed(wsg) >= DCC_TORQ_MIN) &&
                                    ($signed(wsg) <= DCC_TORQ_MAX);
         DCC_A_MOT_TLIM, DCC_A_BRK_TLIM:
            range_ok = (req.wdata <= DCC_TORQ_MAX);
         DCC_A_SPECIAL: range_ok = ((req.wdata & ~DCC_SPECIAL_MASK) == 16'h0000);
         DCC_A_VIN: range_ok = ((req.wdata & ~DCC_VIN_MASK) == 16'h0000);
         DCC_A_VOUT: range_ok = ((req.wdata & ~DCC_VOUT_MASK) == 16'h0000);
         DCC_A_VOLT_REF: range_ok = (req.wdata <= DCC_PCT_MAX);
         DCC_A_AO1, DCC_A_AO2: range_ok = ($signed(wsg) >= DCC_AO_MIN) &&
                                          ($signed(wsg) <= DCC_AO_MAX);
         default: range_ok = 1'b0; // State words and holes refuse writes
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Control bank write; only accepted values are stored
   logic ctl_wr; // Accepted control write
   assign ctl_wr = req.valid && req.write && in_ctl_bank && range_ok;

   always_ff @(posedge clock) begin
      if (rst) begin
         freq_ref <= 16'h0000;
         proc_set <= 16'h0000;
         proc_fb <= 16'h0000;
         torq_ref <= 16'h0000;
         fwd_lim <= 16'h0000;
         rev_lim <= 16'h0000;
         mot_tlim <= 16'h0000;
         brk_tlim <= 16'h0000;
         vin <= 10'h000;
         vout <= 4'h0;
         volt_ref <= 16'h0000;
         ao_one <= 16'h0000;
         ao_two <= 16'h0000;
         special_r <= 6'h00;
         run_cmd_r <= 16'h0000;
      end else if (ctl_wr) begin
         unique case (req.addr)
            DCC_A_RUN_CMD: run_cmd_r <= req.wdata;
            DCC_A_FREQ_REF: freq_ref <= req.wdata;
            DCC_A_PROC_SET: proc_set <= req.wdata;
            DCC_A_PROC_FB: proc_fb <= req.wdata;
            DCC_A_TORQ_REF: torq_ref <= req.wdata;
            DCC_A_FWD_LIM: fwd_lim <= req.wdata;
            DCC_A_REV_LIM: rev_lim <= req.wdata;
            DCC_A_MOT_TLIM: mot_tlim <= req.wdata;
            DCC_A_BRK_TLIM: brk_tlim <= req.wdata;
            DCC_A_SPECIAL: special_r <= req.wdata[5:0];
            DCC_A_VIN: vin <= req.wdata[9:0];
            DCC_A_VOUT: vout <= req.wdata[3:0];
            DCC_A_VOLT_REF: volt_ref <= req.wdata;
            DCC_A_AO1: ao_one <= req.wdata;
            DCC_A_AO2: ao_two <= req.wdata;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Run command decode to one-cycle control pulses and held levels
   always_ff @(posedge clock) begin
      if (rst) begin
         ctl.run_fwd <= 1'b0;
         ctl.run_rev <= 1'b0;
         ctl.jog <= 1'b0;
         ctl.stop_req <= 1'b0;
         ctl.coast_req <= 1'b0;
         ctl.fault_reset <= 1'b0;
         ctl.motor_sel <= 2'b00;
         ctl.torq_ctrl_dis <= 1'b0;
         ctl.energy_clear <= 1'b0;
         ctl.preexc_req <= 1'b0;
         ctl.dc_brake_req <= 1'b0;
      end else begin
         // Stop and reset requests are pulses; run levels persist
         ctl.stop_req <= 1'b0;
         ctl.coast_req <= 1'b0;
         ctl.fault_reset <= 1'b0;
         // Undefined codes never reach here: range_ok refused them
         if (ctl_wr && req.addr == DCC_A_RUN_CMD) begin
            unique case (req.wdata)
               DCC_CMD_FWD: begin
                  ctl.run_fwd <= 1'b1;
                  ctl.run_rev <= 1'b0;
                  ctl.jog <= 1'b0;
               end
               DCC_CMD_REV: begin
                  ctl.run_fwd <= 1'b0;
                  ctl.run_rev <= 1'b1;
                  ctl.jog <= 1'b0;
               end
               DCC_CMD_JOG_F: begin
                  ctl.run_fwd <= 1'b1;
                  ctl.run_rev <= 1'b0;
                  ctl.jog <= 1'b1;
               end
               DCC_CMD_JOG_R: begin
                  ctl.run_fwd <= 1'b0;
                  ctl.run_rev <= 1'b1;
                  ctl.jog <= 1'b1;
               end
               DCC_CMD_STOP: begin
                  ctl.run_fwd <= 1'b0;
                  ctl.run_rev <= 1'b0;
                  ctl.jog <= 1'b0;
                  ctl.stop_req <= 1'b1;
               end
               DCC_CMD_COAST: begin
                  ctl.run_fwd <= 1'b0;
                  ctl.run_rev <= 1'b0;
                  ctl.jog <= 1'b0;
                  ctl.coast_req <= 1'b1;
               end
               DCC_CMD_FRESET: ctl.fault_reset <= 1'b1;
               DCC_CMD_JOG_STOP: begin
                  // Jog stop only ends a jog, not a normal run
                  if (ctl.jog) begin
                     ctl.run_fwd <= 1'b0;
                     ctl.run_rev <= 1'b0;
                     ctl.jog <= 1'b0;
                     ctl.stop_req <= 1'b1;
                  end
               end
               default: ;
            endcase
         end
         // Special word fields live here too, so ctl has a single writer
         ctl.motor_sel <= special_r[1:0];
         ctl.torq_ctrl_dis <= special_r[DCC_SP_TORQ_DIS];
         ctl.energy_clear <= special_r[DCC_SP_ENERGY_CLR];
         ctl.preexc_req <= special_r[DCC_SP_PREEXC];
         ctl.dc_brake_req <= special_r[DCC_SP_DC_BRAKE];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State words, priority fault over power-off over run states
   logic [15:0] state1; // Primary state code
   logic [15:0] state2; // Secondary state word
   always_comb begin
      if (drv_fault) state1 = DCC_ST_FAULT;
      else if (drv_power_off) state1 = DCC_ST_POWER_OFF_STATE;
      else if (drv_running && drv_reverse) state1 = DCC_ST_REV;
      else if (drv_running) state1 = DCC_ST_FWD;
      else if (drv_preexcited) state1 = DCC_ST_PREEXC;
      else state1 = DCC_ST_STOP;
   end
   assign state2 = {13'h0000, special_r[1:0], drv_ready};

   ////////////////////////////////////////////////////////////////////////
   // Read mux for the control bank
   logic [15:0] ctl_rdata; // Control-bank read value
   logic ctl_rd_ok; // Address is mapped
   always_comb begin
      ctl_rd_ok = 1'b1;
      unique case (req.addr)
         DCC_A_RUN_CMD: ctl_rdata = run_cmd_r;
         DCC_A_FREQ_REF: ctl_rdata = freq_ref;
         DCC_A_PROC_SET: ctl_rdata = proc_set;
         DCC_A_PROC_FB: ctl_rdata = proc_fb;
         DCC_A_TORQ_REF: ctl_rdata = torq_ref;
         DCC_A_FWD_LIM: ctl_rdata = fwd_lim;
         DCC_A_REV_LIM: ctl_rdata = rev_lim;
         DCC_A_MOT_TLIM: ctl_rdata = mot_tlim;
         DCC_A_BRK_TLIM: ctl_rdata = brk_tlim;
         DCC_A_SPECIAL: ctl_rdata = {10'h000, special_r};
         DCC_A_VIN: ctl_rdata = {6'h00, vin};
         DCC_A_VOUT: ctl_rdata = {12'h000, vout};
         DCC_A_VOLT_REF: ctl_rdata = volt_ref;
         DCC_A_AO1: ctl_rdata = ao_one;
         DCC_A_AO2: ctl_rdata = ao_two;
         DCC_A_STATE1: ctl_rdata = state1;
         DCC_A_STATE2: ctl_rdata = state2;
         default: begin
            ctl_rdata = 16'h0000;
            ctl_rd_ok = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Parameter access gating; store answers in the next cycle
   logic par_refuse; // Parameter access refused
   logic par_pend_r; // Waiting for store read data
   always_comb begin
      par_refuse = factory_addr;
      if (!req.write && alias_addr) par_refuse = 1'b1;
      if (req.write && par_read_only) par_refuse = 1'b1;
      if (req.write && par_run_locked && drv_running)
         par_refuse = 1'b1;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         par <= '0;
         par_pend_r <= 1'b0;
      end else begin
         par.valid <= req.valid && !in_ctl_bank && !par_refuse;
         par.write <= req.write;
         par.commit_nv <= req.write && !alias_addr;
         par.addr <= req.addr[14:0];
         par.wdata <= req.wdata;
         par_pend_r <= req.valid && !in_ctl_bank && !par_refuse && !req.write;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Answer: control bank one cycle after request, parameter reads two
   always_ff @(posedge clock) begin
      if (rst) begin
         rsp <= '0;
      end else begin
         rsp.done <= 1'b0;
         rsp.error <= 1'b0;
         if (par_pend_r) begin
            rsp.done <= 1'b1;
            rsp.rdata <= par_rdata;
         end else if (req.valid) begin
            if (in_ctl_bank) begin
               rsp.done <= 1'b1;
               rsp.error <= req.write ? !range_ok : !ctl_rd_ok;
               rsp.rdata <= req.write ? 16'h0000 : ctl_rdata;
            end else if (par_refuse || req.write) begin
               rsp.done <= 1'b1;
               rsp.error <= par_refuse;
               rsp.rdata <= 16'h0000;
            end
         end
      end
   end

endmodule // dcc_regs

/* File: shared/dcc_pkg.sv */
package dcc_pkg;
   // Register addresses of the control bank
   localparam logic [15:0] DCC_A_RUN_CMD = 16'h2000;
   localparam logic [15:0] DCC_A_FREQ_REF = 16'h2001;
   localparam logic [15:0] DCC_A_PROC_SET = 16'h2002;
   localparam logic [15:0] DCC_A_PROC_FB = 16'h2003;
   localparam logic [15:0] DCC_A_TORQ_REF = 16'h2004;
   localparam logic [15:0] DCC_A_FWD_LIM = 16'h2005;
   localparam logic [15:0] DCC_A_REV_LIM = 16'h2006;
   localparam logic [15:0] DCC_A_MOT_TLIM = 16'h2007;
   localparam logic [15:0] DCC_A_BRK_TLIM = 16'h2008;
   localparam logic [15:0] DCC_A_SPECIAL = 16'h2009;
   localparam logic [15:0] DCC_A_VIN = 16'h200A;
   localparam logic [15:0] DCC_A_VOUT = 16'h200B;
   localparam logic [15:0] DCC_A_VOLT_REF = 16'h200C;
   localparam logic [15:0] DCC_A_AO1 = 16'h200D;
   localparam logic [15:0] DCC_A_AO2 = 16'h200E;
   localparam logic [15:0] DCC_A_STATE1 = 16'h2100;
   localparam logic [15:0] DCC_A_STATE2 = 16'h2101;
   // Parameter space layout
   localparam logic [7:0] DCC_FACTORY_GROUP = 8'h63;
   localparam int DCC_ALIAS_BIT = 15;
   // Value limits
   localparam logic [15:0] DCC_PCT_MAX = 16'h03E8;
   localparam logic signed [15:0] DCC_TORQ_MAX = 16'sh0BB8;
   localparam logic signed [15:0] DCC_TORQ_MIN = -16'sh0BB8;
   localparam logic signed [15:0] DCC_AO_MAX = 16'sh03E8;
   localparam logic signed [15:0] DCC_AO_MIN = -16'sh03E8;
   localparam logic [15:0] DCC_VIN_MASK = 16'h03FF;
   localparam logic [15:0] DCC_VOUT_MASK = 16'h000F;
   localparam logic [15:0] DCC_SPECIAL_MASK = 16'h003F;
   // Run command codes
   localparam logic [15:0] DCC_CMD_FWD = 16'h0001;
   localparam logic [15:0] DCC_CMD_REV = 16'h0002;
   localparam logic [15:0] DCC_CMD_JOG_F = 16'h0003;
   localparam logic [15:0] DCC_CMD_JOG_R = 16'h0004;
   localparam logic [15:0] DCC_CMD_STOP = 16'h0005;
   localparam logic [15:0] DCC_CMD_COAST = 16'h0006;
   localparam logic [15:0] DCC_CMD_FRESET = 16'h0007;
   localparam logic [15:0] DCC_CMD_JOG_STOP = 16'h0008;
   // Primary state codes
   localparam logic [15:0] DCC_ST_FWD = 16'h0001;
   localparam logic [15:0] DCC_ST_REV = 16'h0002;
   localparam logic [15:0] DCC_ST_STOP = 16'h0003;
   localparam logic [15:0] DCC_ST_FAULT = 16'h0004;
   localparam logic [15:0] DCC_ST_POWER_OFF_STATE = 16'h0005;
   localparam logic [15:0] DCC_ST_PREEXC = 16'h0006;
   // Special control word bit positions
   localparam int DCC_SP_TORQ_DIS = 2;
   localparam int DCC_SP_ENERGY_CLR = 3;
   localparam int DCC_SP_PREEXC = 4;
   localparam int DCC_SP_DC_BRAKE = 5;

   // Access request from the protocol engine
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dcc_req_s;

   // Answer to the protocol engine
   typedef struct packed {
      logic done;
      logic error;
      logic [15:0] rdata;
   } dcc_rsp_s;

   // Parameter store request
   typedef struct packed {
      logic valid;
      logic write;
      logic commit_nv;
      logic [14:0] addr;
      logic [15:0] wdata;
   } dcc_par_s;

   // Decoded control outputs
   typedef struct packed {
      logic run_fwd;
      logic run_rev;
      logic jog;
      logic stop_req;
      logic coast_req;
      logic fault_reset;
      logic [1:0] motor_sel;
      logic torq_ctrl_dis;
      logic energy_clear;
      logic preexc_req;
      logic dc_brake_req;
   } dcc_ctl_s;
endpackage

/* File: tb/dcc_regs_assertions.sv */
`timescale 1ns/1ps
module dcc_regs_chk
   import dcc_pkg::*;
#(
   parameter logic [15:0] FMAX = 16'h9C40 // Max frequency, 0.01 Hz units
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Access and store ports
   input wire dcc_req_s req,
   input wire dcc_rsp_s rsp,
   input wire dcc_par_s par,
   input wire logic par_run_locked,
   input wire logic par_read_only,
   // Status and outputs
   input wire logic drv_running,
   input wire dcc_ctl_s ctl,
   input wire logic [15:0] torq_ref
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Request classes at the taken edge
   wire logic wr = req.valid && req.write;
   wire logic ctlb = req.addr[15:9] == 7'h10; // 0x20xx or 0x21xx
   wire logic fac = req.addr[14:8] == 7'h63;
   wire logic lck = par_read_only || (par_run_locked && drv_running);
   wire logic cmd = wr && req.addr == DCC_A_RUN_CMD;
   // A refusal never reaches the store
   sequence s_err;
      rsp.done && rsp.error && !par.valid;
   endsequence
   sequence s_ram;
      par.valid && par.write && !par.commit_nv && rsp.done;
   endsequence

   chk_bank_answer: assert property (
      req.valid && ctlb |=> rsp.done && !par.valid)
      else $error("control bank access not answered next cycle");
   chk_factory_refused: assert property (
      req.valid && fac |=> s_err)
      else $error("factory group access not refused");
   chk_alias_read: assert property (
      req.valid && !req.write && req.addr[15] |=> s_err)
      else $error("alias read not refused");
   chk_alias_write: assert property (
      wr && req.addr[15] && !fac && !lck
      |=> s_ram ##0 par.addr == $past(req.addr[14:0]))
      else $error("alias write not sent as RAM-only");
   chk_lock_refused: assert property (
      wr && !ctlb && lck |=> s_err)
      else $error("locked parameter write not refused");
   chk_stop_pulse: assert property (
      cmd && req.wdata == DCC_CMD_STOP |=> ctl.stop_req ##1 !ctl.stop_req)
      else $error("stop command not a single pulse");
   chk_undef_ignored: assert property (
      cmd && (req.wdata == 16'h0000 || req.wdata > 16'h0008)
      |=> rsp.error && $stable({ctl.run_fwd, ctl.run_rev, ctl.jog}))
      else $error("undefined command changed the drive");
   chk_torq_range: assert property (
      wr && req.addr == DCC_A_TORQ_REF
      && ($signed(req.wdata) > 3000 || $signed(req.wdata) < -3000)
      |=> rsp.error && $stable(torq_ref))
      else $error("torque reference out of range stored");
endmodule // dcc_regs_chk

bind dcc_regs dcc_regs_chk #(.FMAX(FMAX)) u_chk (.clock(clock), .rst(rst),
   .req(req), .rsp(rsp), .par(par), .par_run_locked(par_run_locked),
   .par_read_only(par_read_only), .drv_running(drv_running), .ctl(ctl),
   .torq_ref(torq_ref));

/* File: tb/dcc_store_model.sv */
`timescale 1ns/1ps
module dcc_store_model
   import dcc_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Store port of the block
   input wire dcc_par_s par,
   input wire logic [15:0] req_addr,
   output logic [15:0] par_rdata,
   // Lock flags of the addressed parameter
   output logic par_run_locked,
   output logic par_read_only
);
   logic [14:0] addr_r; // Address of the read in flight
   logic hold_r; // Read data still owed to the block
   logic [15:0] junk_r; // Filler that changes, so stale data never matches

   ////////////////////////////////////////////////////////////////////////
   // Track a read and scramble the idle filler
   always_ff @(posedge clock) begin
      hold_r <= !rst && par.valid && !par.write;
      if (par.valid) begin
         addr_r <= par.addr;
      end
      junk_r <= rst ? 16'hA5A5 : junk_r + 16'h3C5B;
   end

   // Data is shown while any store request is out and for the cycle after a read
   assign par_rdata = (par.valid || hold_r) ?
      {1'b0, par.valid ? par.addr : addr_r} ^ 16'h5A5A : junk_r;
   // Index 0x10 of a group is run-locked, 0x11 never writable
   assign par_run_locked = req_addr[7:0] == 8'h10;
   assign par_read_only = req_addr[7:0] == 8'h11;
endmodule // dcc_store_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   import dcc_pkg::*;
   localparam logic [15:0] FMX = 16'h1388; // Smaller max frequency
   logic clock = 1'b0;
   logic rst = 1'b1;
   dcc_req_s req = '0;
   dcc_rsp_s rsp;
   dcc_par_s par;
   dcc_par_s pc; // Store request seen at the answer
   dcc_ctl_s ctl;
   logic [15:0] par_rdata;
   logic par_run_locked;
   logic par_read_only;
   logic [5:0] drv = '0; // ready, preexc, power_off_state, fault, reverse, running
   logic [15:0] ov [15]; // Register copies by bank index
   logic [9:0] vin;
   logic [3:0] vout;
   logic [15:0] rd; // Last answer data
   logic er; // Last answer error
   logic [15:0] mem [15]; // Bench copy of the bank
   logic [31:0] rs = 32'd65265; // Random state
   int num_errors = 0;
   int n_checks = 0;
   int lim [15] = '{8, FMX, 1000, 1000, 3000, FMX, FMX, 3000, 3000, 63,
      1023, 15, 1000, 1000, 1000};

   always #50 clock = ~clock;

   dcc_regs #(.FMAX(FMX)) uut (.clock(clock), .rst(rst), .req(req),
      .rsp(rsp), .par(par), .par_rdata(par_rdata),
      .par_run_locked(par_run_locked), .par_read_only(par_read_only),
      .drv_running(drv[0]), .drv_reverse(drv[1]), .drv_fault(drv[2]),
      .drv_power_off(drv[3]), .drv_preexcited(drv[4]), .drv_ready(drv[5]),
      .ctl(ctl), .freq_ref(ov[1]), .proc_set(ov[2]), .proc_fb(ov[3]),
      .torq_ref(ov[4]), .fwd_lim(ov[5]), .rev_lim(ov[6]), .mot_tlim(ov[7]),
      .brk_tlim(ov[8]), .vin(vin), .vout(vout), .volt_ref(ov[12]),
      .ao_one(ov[13]), .ao_two(ov[14]));
   dcc_store_model u_store (.clock(clock), .rst(rst), .par(par),
      .req_addr(req.addr), .par_rdata(par_rdata),
      .par_run_locked(par_run_locked), .par_read_only(par_read_only));

   ////////////////////////////////////////////////////////////////////////
   // Xorshift source, fixed seed so runs repeat
   function automatic logic [15:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs[15:0];
   endfunction

   // Bank value legality; signed fields are 4, 13 and 14
   function automatic bit ok(int a, logic [15:0] v);
      int s;
      s = $signed(v);
      if (a == 4 || a > 12) begin
         return s >= -lim[a] && s <= lim[a];
      end
      return v <= lim[a] && (a != 0 || v != 0);
   endfunction

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One request, held for a single taken edge, answer waited for
   task automatic acc(logic w, logic [15:0] a, logic [15:0] d);
      int k;
      @(posedge clock);
      req <= '{1'b1, w, a, d};
      @(posedge clock);
      req.valid <= 1'b0;
      k = 0;
      do begin
         @(negedge clock);
         k++;
      end while (rsp.done !== 1'b1 && k < 4);
      if (rsp.done !== 1'b1) begin
         num_errors++;
         $display("[ERR] answer expected 1 seen %b", rsp.done);
         final_report();
      end
      er = rsp.error;
      rd = rsp.rdata;
      pc = par;
   endtask

   // Write to the bank, then compare refusal, outputs and readback
   task automatic wr_bank(int a, logic [15:0] v);
      logic g;
      g = ok(a, v);
      acc(1'b1, DCC_A_RUN_CMD + 16'(a), v);
      chk("range_err", !g, er);
      if (g) begin
         mem[a] = v;
      end
      if (a == 10) begin
         chk("vin", mem[a][9:0], vin);
      end else if (a == 11) begin
         chk("vout", mem[a][3:0], vout);
      end else begin
         chk("out", mem[a], ov[a]);
      end
      acc(1'b0, DCC_A_RUN_CMD + 16'(a), 16'h0000);
      chk("readback", mem[a], rd);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int a;
      logic [15:0] v;
      logic w, run, e;
      static int bi [10] = '{3, 5, 4, 3, 3, 2, 1, 0, 3, 3}; // Bit per code
      static logic [5:0] sv [6] = '{6'h00, 6'h01, 6'h03, 6'h10, 6'h09, 6'h0F};
      static logic [15:0] se [6] = '{16'h3, 16'h1, 16'h2, 16'h6, 16'h5, 16'h4};
      static logic [18:0] pt [12] = '{{3'b000, 16'h0507}, {3'b100, 16'h8007},
         {3'b100, 16'h0007}, {3'b001, 16'h8007}, {3'b001, 16'h6301},
         {3'b101, 16'h6301}, {3'b101, 16'hE301}, {3'b100, 16'h0010},
         {3'b111, 16'h0010}, {3'b111, 16'h8010}, {3'b101, 16'h0011},
         {3'b010, 16'h0011}}; // write, running, refused, address
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      for (a = 0; a < 15; a++) begin
         mem[a] = 16'h0000;
         acc(1'b0, DCC_A_RUN_CMD + 16'(a), 16'h0000);
         chk("reset", 16'h0000, rd);
      end
      $display("test reset values done");
      for (a = 1; a < 15; a++) begin
         if (a == 9) continue;
         wr_bank(a, 16'(lim[a]));
         wr_bank(a, 16'(lim[a]+1));
         wr_bank(a, 16'(-lim[a]));
         wr_bank(a, 16'(-lim[a] - 1));
      end
      repeat (30) begin
         a = 1 + int'(rnd() % 16'd14);
         a = (a == 9) ? 12 : a;
         v = rnd() % 16'(lim[a] + 1);
         v = ((a == 4 || a > 12) && v[0]) ? -v : v;
         wr_bank(a, v);
      end
      $display("test value ranges done");
      for (a = 0; a < 10; a++) begin
         acc(1'b1, DCC_A_RUN_CMD, 16'(a));
         chk("cmd_err", a == 0 || a == 9, er);
         chk("cmd_ctl", a > 0 && a < 8, 1'({ctl.run_fwd, ctl.run_rev,
            ctl.jog, ctl.stop_req, ctl.coast_req, ctl.fault_reset}
            >> bi[a]));
      end
      // Jog stop must end an active jog with a stop pulse
      acc(1'b1, DCC_A_RUN_CMD, DCC_CMD_JOG_R);
      acc(1'b1, DCC_A_RUN_CMD, DCC_CMD_JOG_STOP);
      chk("jog_stop", 4'h1, {ctl.run_fwd, ctl.run_rev, ctl.jog,
         ctl.stop_req});
      acc(1'b0, DCC_A_RUN_CMD, 16'h0000);
      chk("cmd_read", DCC_CMD_JOG_STOP, rd);
      $display("test run commands done");
      for (a = 0; a < 4; a++) begin
         v = (rnd() & 16'h003C) | 16'(a);
         @(posedge clock);
         drv <= {a[0], 5'd0};
         acc(1'b1, DCC_A_SPECIAL, v);
         @(negedge clock);
         chk("special", {v[1:0], v[2], v[3], v[4], v[5]}, {ctl.motor_sel,
            ctl.torq_ctrl_dis, ctl.energy_clear, ctl.preexc_req,
            ctl.dc_brake_req});
         acc(1'b0, DCC_A_STATE2, 16'h0000);
         chk("state2", {v[1:0], a[0]}, rd);
      end
      for (a = 0; a < 6; a++) begin
         @(posedge clock);
         drv <= sv[a];
         acc(1'b0, DCC_A_STATE1, 16'h0000);
         chk("state1", se[a], rd);
      end
      acc(1'b1, DCC_A_STATE1, 16'h0001);
      chk("state_wr", 1'b1, er);
      $display("test state words done");
      for (a = 0; a < 12; a++) begin
         {w, run, e, v} = pt[a];
         @(posedge clock);
         drv <= {5'd0, run};
         acc(w, v, 16'h1234);
         chk("par_err", e, er);
         if (!w && !e) begin
            chk("par_rd", v ^ 16'h5A5A, rd);
         end
         if (w && !e) begin
            chk("par_req", {2'b11, !v[15], v[14:0]}, {pc.valid, pc.write,
               pc.commit_nv, pc.addr});
            chk("par_wdata", 16'h1234, pc.wdata);
         end
      end
      $display("test parameter access done");
      final_report();
   end
endmodule // tb
